/* File: inc/acsp_defs.svh */
`ifndef ACSP_DEFS_SVH
`define ACSP_DEFS_SVH

// serial word layout
`define ACSP_WORD_BITS    16
`define ACSP_ADDR_BITS    8
`define ACSP_CNT_LAST     4'hF
`define ACSP_CNT_ADDR     4'h7
`define ACSP_CNT_DATA0    4'h8

// register map
`define ACSP_NREG         8
`define ACSP_ADDR_CTRL    8'h00
`define ACSP_BIT_INIT     7
`define ACSP_BIT_RDBK     0
`define ACSP_REG_RESET    8'h00

// strap-mode entry: reset pin high for longer than the longest legal pulse
`define ACSP_STRAP_NS     1000
`define ACSP_CORE_MHZ     250
`define ACSP_STRAP_CYC    ((`ACSP_STRAP_NS * `ACSP_CORE_MHZ) / 1000)

`endif

/* File: inc/acsp_pkg.sv */
package acsp_pkg;

   // quantised analog level codes on the two four-level strap pins
   typedef enum logic [1:0] {
      ACSP_LVL_ZERO = 2'h0,
      ACSP_LVL_3_8  = 2'h1,
      ACSP_LVL_5_8  = 2'h2,
      ACSP_LVL_FULL = 2'h3
   } acsp_level_t;

   // configuration mode, gray along reg -> pending -> strap
   typedef enum logic [1:0] {
      ACSP_MODE_REG   = 2'h0,
      ACSP_MODE_PEND  = 2'h1,
      ACSP_MODE_STRAP = 2'h3
   } acsp_mode_t;

   typedef struct packed {
      logic ref_ext;
      logic fmt_twos;
      logic iface_cmos;
      logic power_down;
      logic stby_a;
      logic stby_b;
      logic interleaved_output_mode;
      logic strap_mode;
   } acsp_cfg_t;

endpackage

/* File: design/acsp_top.sv */
`timescale 1ns/10ps
`include "acsp_defs.svh"
// Contract
// - reset pin held high selects strap mode
// - shift clock level picks internal or external reference
// - enable level picks output format and interface
// - strap pins decode power down and standby
// - all strap pins high selects interleaved output
// - reset pin low makes pins a serial port
// - strap pins still apply in register mode
// - shift only while enable low, falling edges
// - sixteenth falling edge commits the word
// - incomplete trailing bits are discarded
// - several words per enable period, each committed
// - first eight bits address, next eight data
// - reset pin pulse returns registers to defaults
// - init bit clears all registers, self-clears
// - readback mode blocks writes until cleared
// - readback shifts addressed register data out
// - readback works for either output interface
// - readback pin driven low when mode off
module acsp_top (
   input  wire logic                       i_core_clk,
   input  wire logic                       i_srst,
   input  wire logic                       i_reset_pin,
   input  wire logic                       i_shift_clk,
   input  wire logic                       i_serial_enable_n,
   input  wire logic                       i_shift_input,
   input  wire logic [1:0]                 i_shift_clk_level,
   input  wire logic [1:0]                 i_serial_enable_level,
   input  wire logic                       i_strap_pin_1,
   input  wire logic                       i_strap_pin_2,
   input  wire logic                       i_strap_pin_3,
   output logic                            o_readback_output,
   output acsp_pkg::acsp_cfg_t             o_cfg,
   output acsp_pkg::acsp_mode_t            o_mode,
   output logic [`ACSP_NREG-1:0][7:0]      o_regs,
   output logic                            o_write_pulse
);

   // shift-domain state: cleared whenever the enable is high
   typedef struct packed {
      logic [3:0]  cnt;
      logic [14:0] sr;
      logic [7:0]  addr;
   } acsp_shift_t;

   // register file lives on the link clock so readback meets half a period
   typedef struct packed {
      logic [`ACSP_NREG-1:0][7:0] regs;
      logic                       tgl;
   } acsp_rf_t;

   // core-domain state
   typedef struct packed {
      logic [1:0]                 pin_s;
      logic [1:0]                 rst_s;
      logic [2:0]                 tgl_s;
      logic [1:0][1:0]            sclk_lvl_s;
      logic [1:0][1:0]            sen_lvl_s;
      logic [1:0][2:0]            ctrl_s;
      logic [15:0]                hi_cnt;
      acsp_pkg::acsp_mode_t       mode;
      acsp_pkg::acsp_cfg_t        cfg;
      logic [`ACSP_NREG-1:0][7:0] regs;
      logic                       wr_pulse;
   } acsp_core_t;

   // hold count for strap entry; the counter is wide enough for any default
   localparam logic [15:0] STRAP_CYC = 16'(`ACSP_STRAP_CYC);

   // link side, clocked by the shift clock falling edge
   acsp_shift_t sh_q;
   acsp_shift_t sh_d;
   acsp_rf_t    rf_q;
   acsp_rf_t    rf_d;

   // core side, clocked by the core clock only
   acsp_core_t  st_q;
   acsp_core_t  st_d;

   // readback flop runs on the rising shift clock edge
   logic        rb_q;
   logic        rb_d;

   // sticky that stretches a short reset pin pulse for the core
   logic        rst_catch_q;

   // link-side helpers, all combinational
   logic        commit;
   logic [15:0] word;
   logic [7:0]  rdata;
   logic        rdbk_on;

   // a whole word is present on this falling edge
   assign commit  = (!i_serial_enable_n) && (sh_q.cnt == `ACSP_CNT_LAST);
   assign word    = {sh_q.sr, i_shift_input};
   assign rdbk_on = rf_q.regs[0][`ACSP_BIT_RDBK];

   // next shift state: count and shift one bit per falling edge
   always_comb begin
      sh_d     = sh_q;
      sh_d.cnt = sh_q.cnt + 4'h1;                    // wraps to 0 after 16 for the next word
      sh_d.sr  = {sh_q.sr[13:0], i_shift_input};
      // the address byte is whole on the eighth edge; kept for readback
      if (sh_q.cnt == `ACSP_CNT_ADDR) begin
         sh_d.addr = {sh_q.sr[6:0], i_shift_input};
      end
   end

   // enable high clears the counter asynchronously, so partial words vanish
   always_ff @(negedge i_shift_clk or posedge i_serial_enable_n) begin
      if (i_serial_enable_n) begin
         sh_q <= '0;
      end else begin
         sh_q <= sh_d;
      end
   end

   // register write decode on the sixteenth edge
   always_comb begin
      rf_d = rf_q;
      if (commit) begin
         // every whole word toggles, blocked or not, so the core copies it
         rf_d.tgl = ~rf_q.tgl;
         if (word[15:8] == `ACSP_ADDR_CTRL) begin
            if (word[`ACSP_BIT_INIT]) begin
               rf_d.regs = '0;                       // init bit never stores, so it reads 0
            end else begin
               rf_d.regs[0] = {7'h00, word[`ACSP_BIT_RDBK]}; // control stays writable
            end
         end else if (!rdbk_on && (word[15:8] < 8'(`ACSP_NREG))) begin
            rf_d.regs[word[10:8]] = word[7:0];
         end
      end
   end

   // the pin itself resets the file, so a short pulse needs no clock
   always_ff @(negedge i_shift_clk or posedge i_reset_pin) begin
      if (i_reset_pin) begin
         rf_q <= '0;
      end else begin
         rf_q <= rf_d;
      end
   end

   // readback data of the latched address; unmapped addresses read zero
   always_comb begin
      rdata = 8'h00;
      if (sh_q.addr < 8'(`ACSP_NREG)) begin
         rdata = rf_q.regs[sh_q.addr[2:0]];
      end
   end

   // launch on rising edges so the controller can sample on falling ones
   always_comb begin
      rb_d = 1'b0;                                   // low when off, never floated
      // data bits count down as the counter climbs through the second byte
      if (rdbk_on && !i_serial_enable_n && (sh_q.cnt >= `ACSP_CNT_DATA0)) begin
         rb_d = rdata[~sh_q.cnt[2:0]];               // bit 7 first
      end
   end

   // independent of the sample interface setting
   always_ff @(posedge i_shift_clk or posedge i_reset_pin) begin
      if (i_reset_pin) begin
         rb_q <= 1'b0;
      end else begin
         rb_q <= rb_d;
      end
   end

   // readback leaves straight from its flop, no logic after it
   assign o_readback_output = rb_q;

   // catch even a 10 ns reset pulse for the core copy; acked after sync
   always_ff @(posedge i_core_clk or posedge i_reset_pin) begin
      if (i_reset_pin) begin
         rst_catch_q <= 1'b1;
      end else if (st_q.rst_s[1] || i_srst) begin
         rst_catch_q <= 1'b0;
      end
   end

   // core next state: synchronisers, mode tracking, decode and copy
   always_comb begin
      st_d            = st_q;

      // two flops on every pin level and on the toggle before any decode
      st_d.pin_s      = {st_q.pin_s[0], i_reset_pin};
      st_d.rst_s      = {st_q.rst_s[0], rst_catch_q};
      st_d.tgl_s      = {st_q.tgl_s[1:0], rf_q.tgl};
      st_d.sclk_lvl_s = {st_q.sclk_lvl_s[0], i_shift_clk_level};
      st_d.sen_lvl_s  = {st_q.sen_lvl_s[0], i_serial_enable_level};
      st_d.ctrl_s     = {st_q.ctrl_s[0], {i_strap_pin_1, i_strap_pin_2, i_strap_pin_3}};

      // the pulse is high only in the cycle after a toggle is seen
      st_d.wr_pulse   = 1'b0;

      // mode: a level held past the longest pulse means the pin is strapped high
      case (st_q.mode)
         acsp_pkg::ACSP_MODE_REG: begin
            // counting starts from zero on every entry to pending
            st_d.hi_cnt = 16'h0000;
            if (st_q.pin_s[1]) begin
               st_d.mode = acsp_pkg::ACSP_MODE_PEND;
            end
         end
         acsp_pkg::ACSP_MODE_PEND: begin
            // cannot wrap: the mode leaves pending long before the top
            st_d.hi_cnt = st_q.hi_cnt + 16'h0001;
            if (!st_q.pin_s[1]) begin
               st_d.mode = acsp_pkg::ACSP_MODE_REG;  // a reset pulse, back to registers
            end else if (st_q.hi_cnt >= STRAP_CYC - 16'h0001) begin
               st_d.mode = acsp_pkg::ACSP_MODE_STRAP;
            end
         end
         acsp_pkg::ACSP_MODE_STRAP: begin
            // the pin falling hands the pins back to the serial port
            if (!st_q.pin_s[1]) begin
               st_d.mode = acsp_pkg::ACSP_MODE_REG;
            end
         end
         default: begin
            // the unused code falls back to register mode
            st_d.mode = acsp_pkg::ACSP_MODE_REG;
         end
      endcase

      // the strap pins act in every mode; reserved codes run as normal
      st_d.cfg.power_down              = (st_q.ctrl_s[1] == 3'h4);
      st_d.cfg.stby_b                  = (st_q.ctrl_s[1] == 3'h5);
      st_d.cfg.stby_a                  = (st_q.ctrl_s[1] == 3'h6);
      st_d.cfg.interleaved_output_mode = (st_q.ctrl_s[1] == 3'h7);

      // the flag lags the mode by one cycle like every other field
      st_d.cfg.strap_mode = (st_q.mode == acsp_pkg::ACSP_MODE_STRAP);

      // level pins only count in strap mode; registers hold defaults otherwise
      if (st_q.mode == acsp_pkg::ACSP_MODE_STRAP) begin
         st_d.cfg.ref_ext = (st_q.sclk_lvl_s[1] == acsp_pkg::ACSP_LVL_3_8) ||
                            (st_q.sclk_lvl_s[1] == acsp_pkg::ACSP_LVL_5_8);
         st_d.cfg.fmt_twos = (st_q.sen_lvl_s[1] == acsp_pkg::ACSP_LVL_3_8) ||
                             (st_q.sen_lvl_s[1] == acsp_pkg::ACSP_LVL_5_8);
         st_d.cfg.iface_cmos = (st_q.sen_lvl_s[1] == acsp_pkg::ACSP_LVL_5_8) ||
                               (st_q.sen_lvl_s[1] == acsp_pkg::ACSP_LVL_FULL);
      end else if (st_q.mode == acsp_pkg::ACSP_MODE_REG) begin
         st_d.cfg.ref_ext    = 1'b0;
         st_d.cfg.fmt_twos   = 1'b0;
         st_d.cfg.iface_cmos = 1'b0;
      end

      // the file is stable for 16 link periods after a toggle, so a copy is safe
      if (st_q.tgl_s[2] != st_q.tgl_s[1]) begin
         st_d.regs     = rf_q.regs;
         st_d.wr_pulse = 1'b1;
      end

      // a caught pin pulse wins over a copy in the same cycle
      if (st_q.rst_s[1]) begin
         st_d.regs = '0;
      end
   end

   // core register
   always_ff @(posedge i_core_clk) begin
      if (i_srst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // outputs straight from flip-flops
   assign o_cfg         = st_q.cfg;
   assign o_mode        = st_q.mode;
   assign o_regs        = st_q.regs;
   assign o_write_pulse = st_q.wr_pulse;

endmodule

/* File: tb/acsp_top_asserts.sv */
`timescale 1ns/10ps
`include "acsp_defs.svh"
module acsp_top_asserts (
   input  wire logic                        i_core_clk,
   input  wire logic                        i_srst,
   input  wire logic                        i_reset_pin,
   input  wire logic                        i_strap_pin_1,
   input  wire logic                        i_strap_pin_2,
   input  wire logic                        i_strap_pin_3,
   input  wire logic                        o_readback_output,
   input  acsp_pkg::acsp_cfg_t              o_cfg,
   input  acsp_pkg::acsp_mode_t             o_mode,
   input  wire logic [`ACSP_NREG-1:0][7:0]  o_regs,
   input  wire logic                        o_write_pulse
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_srst);
   logic [8:0] pend_q;
   logic [2:0] pins;
   assign pins = {i_strap_pin_1, i_strap_pin_2, i_strap_pin_3};
   // cycles spent pending; saturates so a long hold cannot wrap
   always_ff @(posedge i_core_clk) begin
      if (i_srst || o_mode != acsp_pkg::ACSP_MODE_PEND)
         pend_q <= 9'h000;
      else if (pend_q != 9'h1FF)
         pend_q <= pend_q + 9'h001;
   end
   // pins settled long enough to pass the synchroniser and decode
   sequence pins_steady;
      $stable(pins) [*8];
   endsequence
   sequence pend_to_strap;
      $past(o_mode) == acsp_pkg::ACSP_MODE_PEND ##0 o_mode == acsp_pkg::ACSP_MODE_STRAP;
   endsequence
   AST_PULSE_ONE: assert property (o_write_pulse |=> !o_write_pulse)
      else $error("write pulse longer than one cycle");
   AST_MODE_ORDER: assert property (o_mode == acsp_pkg::ACSP_MODE_REG |=>
      o_mode != acsp_pkg::ACSP_MODE_STRAP) else $error("strap mode entered without wait");
   AST_MODE_REG: assert property (!i_reset_pin [*5] |->
      o_mode == acsp_pkg::ACSP_MODE_REG) else $error("register mode lost with pin low");
   AST_STRAP_FLAG: assert property ($stable(o_mode) [*2] |->
      o_cfg.strap_mode == (o_mode == acsp_pkg::ACSP_MODE_STRAP))
      else $error("strap flag disagrees with mode");
   AST_PIN_DEC_A: assert property (pins_steady |-> o_cfg.power_down == (pins == 3'h4)
      && o_cfg.stby_b == (pins == 3'h5)) else $error("power down or standby b decode");
   AST_PIN_DEC_B: assert property (pins_steady |-> o_cfg.stby_a == (pins == 3'h6)
      && o_cfg.interleaved_output_mode == (pins == 3'h7)) else $error("standby a or mux decode");
   AST_RDBK_LOW: assert property (!o_regs[0][0] [*2] |-> !o_readback_output)
      else $error("readback pin not low while readback off");
   AST_STRAP_COUNT: assert property (pend_to_strap |-> pend_q >= 9'h0F0 && pend_q <= 9'h0FF)
      else $error("strap entry time off");
endmodule
bind acsp_top acsp_top_asserts chk_u (.i_core_clk(i_core_clk), .i_srst(i_srst),
   .i_reset_pin(i_reset_pin), .i_strap_pin_1(i_strap_pin_1), .i_strap_pin_2(i_strap_pin_2),
   .i_strap_pin_3(i_strap_pin_3), .o_readback_output(o_readback_output), .o_cfg(o_cfg),
   .o_mode(o_mode), .o_regs(o_regs), .o_write_pulse(o_write_pulse));

/* File: tb/acsp_ctrl_model.sv */
`timescale 1ns/10ps
// external controller: frames words onto the serial pins, clock idles high
module acsp_ctrl_model (
   output logic       o_shift_clk,
   output logic       o_serial_enable_n,
   output logic       o_shift_input,
   input  wire logic  i_readback_output
);
   initial begin
      o_shift_clk = 1'b1;
      o_serial_enable_n = 1'b0;
      o_shift_input = 1'b0;
      // a first rising enable clears the link counter before any frame
      #10;
      o_serial_enable_n = 1'b1;
   end
   // sends n bits of v from the top; rd keeps the last eight readback bits
   task automatic xfer(input logic [47:0] v, input int n, output logic [7:0] rd);
      rd = 8'h00;
      o_serial_enable_n = 1'b0;
      #25.3; // odd offset keeps shift edges off the core grid
      for (int i = 0; i < n; i++) begin
         o_shift_input = v[47-i];
         #15; // half a shift period; the port takes any rate and duty
         rd = {rd[6:0], i_readback_output};
         o_shift_clk = 1'b0;
         #15;
         o_shift_clk = 1'b1;
      end
      #25;
      o_serial_enable_n = 1'b1;
      o_shift_input = ~o_shift_input; // released line must not keep its value
      #40; // enable stays high a while so back-to-back frames stay apart
   endtask
endmodule

/* File: tb/test_adc_config_serial_port.sv */
`timescale 1ns/10ps
`include "acsp_defs.svh"
module test_adc_config_serial_port;
   logic                 clk = 1'b0, srst = 1'b1, rpin = 1'b0; // pin rises after time zero
   logic                 sclk, sen_n, sdi, sdo, wp;
   logic [1:0]           lc, ls;
   logic [2:0]           pins;
   acsp_pkg::acsp_cfg_t  cfg;
   acsp_pkg::acsp_mode_t mode;
   logic [7:0][7:0]      regs;
   logic [7:0]           exp_r [8];
   logic [7:0]           rd;
   logic [2:0]           codes [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
   int                   fail_count = 0, n_checks = 0, n_pulse = 0, n0;
   acsp_top dut_u (.i_core_clk(clk), .i_srst(srst), .i_reset_pin(rpin), .i_shift_clk(sclk),
      .i_serial_enable_n(sen_n), .i_shift_input(sdi), .i_shift_clk_level(lc),
      .i_serial_enable_level(ls), .i_strap_pin_1(pins[2]), .i_strap_pin_2(pins[1]),
      .i_strap_pin_3(pins[0]), .o_readback_output(sdo), .o_cfg(cfg), .o_mode(mode),
      .o_regs(regs), .o_write_pulse(wp));
   acsp_ctrl_model m_u (.o_shift_clk(sclk), .o_serial_enable_n(sen_n), .o_shift_input(sdi),
      .i_readback_output(sdo));
   always #2 clk = ~clk;
   // commits seen by the core copy
   always @(posedge clk) if (wp === 1'b1) n_pulse++;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
         fail_count++;
      end
   endtask
   task automatic stop_test();
      if (fail_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic wait_pulses(input int n);
      for (int i = 0; i < 400 && n_pulse < n; i++) @(negedge clk);
      if (n_pulse < n) begin
         $display("[ERR] %0t got %h exp %h", $time, n_pulse, n);
         fail_count++;
         stop_test();
      end
      repeat (2) @(negedge clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      n0 = n_pulse;
      m_u.xfer({a, d, 32'h0}, 16, rd);
      wait_pulses(n0 + 1);
      if (a == 8'h00 && d[7]) exp_r = '{default: 8'h00};
      else if (a == 8'h00) exp_r[0] = {7'h00, d[0]};
      else if (a < 8'h08 && !exp_r[0][0]) exp_r[a[2:0]] = d;
   endtask
   task automatic check_regs();
      for (int i = 0; i < 8; i++) chk(regs[i], exp_r[i]);
   endtask
   function automatic acsp_pkg::acsp_cfg_t exp_cfg(input logic [2:0] p, input logic [1:0] c,
                                                   input logic [1:0] s, input logic st);
      exp_cfg = '0;
      exp_cfg.strap_mode = st;
      exp_cfg.ref_ext = st && (c == 2'h1 || c == 2'h2);
      exp_cfg.fmt_twos = st && (s == 2'h1 || s == 2'h2);
      exp_cfg.iface_cmos = st && s[1];
      exp_cfg.power_down = (p == 3'h4);
      exp_cfg.stby_b = (p == 3'h5);
      exp_cfg.stby_a = (p == 3'h6);
      exp_cfg.interleaved_output_mode = (p == 3'h7);
   endfunction
   initial begin
      void'($urandom(32'hE220));
      lc = 2'h0;
      ls = 2'h0;
      pins = 3'h0;
      exp_r = '{default: 8'h00};
      @(negedge clk);
      rpin = 1'b1;
      repeat (3) @(negedge clk);
      srst = 1'b0;
      rpin = 1'b0;
      repeat (26) @(negedge clk);
      // two words then five stray bits in one enable period
      exp_r[2] = 8'($urandom);
      exp_r[3] = 8'($urandom);
      n0 = n_pulse;
      m_u.xfer({8'h02, exp_r[2], 8'h03, exp_r[3], 16'h04FF}, 37, rd);
      wait_pulses(n0 + 2);
      check_regs();
      for (int k = 0; k < 12; k++) begin
         wr(8'($urandom_range(1, 7)), 8'($urandom));
         check_regs();
      end
      wr(8'h41, 8'($urandom));
      check_regs();
      wr(8'h00, 8'h01);
      wr(8'h01, ~exp_r[1]);
      check_regs();
      for (int a = 1; a < 8; a++) begin
         m_u.xfer({8'(a), 8'h00, 32'h0}, 16, rd);
         chk(rd, exp_r[a]);
      end
      m_u.xfer({8'h41, 8'h00, 32'h0}, 16, rd);
      chk(rd, 8'h00);
      wr(8'h00, 8'h00);
      chk({7'h00, sdo}, 8'h00);
      wr(8'h06, 8'($urandom));
      check_regs();
      wr(8'h00, 8'h80);
      check_regs();
      wr(8'h05, 8'h3C);
      rpin = 1'b1;
      repeat (3) @(negedge clk);
      rpin = 1'b0;
      exp_r = '{default: 8'h00};
      repeat (26) @(negedge clk);
      check_regs();
      foreach (codes[i]) begin
         pins = codes[i];
         {lc, ls} = 4'($urandom);
         repeat (10) @(negedge clk);
         chk(8'(cfg), 8'(exp_cfg(pins, lc, ls, 1'b0)));
      end
      rpin = 1'b1;
      repeat (300) @(negedge clk);
      chk(8'(mode), 8'(acsp_pkg::ACSP_MODE_STRAP));
      for (int i = 0; i < 16; i++) begin
         {lc, ls} = 4'(i);
         pins = codes[$urandom_range(0, 4)];
         repeat (10) @(negedge clk);
         chk(8'(cfg), 8'(exp_cfg(pins, lc, ls, 1'b1)));
      end
      rpin = 1'b0;
      repeat (10) @(negedge clk);
      chk(8'(mode), 8'(acsp_pkg::ACSP_MODE_REG));
      stop_test();
   end
endmodule
